// file: verilog/fsp_pkg.sv
/*
 * constants for the flash self-programming control block: control byte
 * layout, timed-sequence windows, readback pointer codes and program time.
 * assumes a 25 mhz cpu clock; the program time count derives from it.
 */
// What this block and the software using it must do
// (RQ1) erase/write blocks rww reads, busy flag set
// (RQ2) software never touches rww section while busy
// (RQ3) vectors in boot section or interrupts off
// (RQ4) read-enable write clears busy, restores reads
// (RQ5) lock command then store within four cycles
// (RQ6) zero data bits 5..0 program lock bits
// (RQ7) pointer ignored while setting lock bits
// (RQ8) software sets data bits 7,6 to one
// (RQ9) lock programming keeps whole flash readable
// (RQ10) eeprom write blocks programming and readback
// (RQ11) software polls eeprom busy before command
// (RQ12) pointer 1 readback returns lock bits
// (RQ13) readback done or timeout clears both bits
// (RQ14) bits clear: load is ordinary flash read
// (RQ15) pointer 0 readback returns fuse low
// (RQ16) pointer 3 readback returns fuse high
// (RQ17) pointer 2 returns extended fuse, bits 2..0
// (RQ18) programmed reads zero, unprogrammed reads one
// (RQ19) reset during write lets write finish
// (RQ20) timed operations last 3.7 to 4.5 ms
// (RQ21) erase, load, write command patterns plus store
// (RQ22) page buffer load clears busy flag
// (RQ23) ready interrupt while enable stays cleared
// (RQ24) read-enable rejected while operation runs
// (RQ25) enable bit held until timed operation ends
package fsp_pkg;
    // -------------------------------------------------------------------
    // control byte layout
    // -------------------------------------------------------------------
    localparam int unsigned BIT_ENABLE   = 0;   // store_prog_enable
    localparam int unsigned BIT_ERASE    = 1;   // page_erase_cmd
    localparam int unsigned BIT_WRITE    = 2;   // page_write_cmd
    localparam int unsigned BIT_LOCK     = 3;   // lock_bit_set
    localparam int unsigned BIT_RWW_EN   = 4;   // rww_read_enable
    localparam int unsigned BIT_BUSY     = 6;   // rww_busy_flag, read only
    localparam int unsigned BIT_IRQ_EN   = 7;   // ready_irq_enable
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    // -------------------------------------------------------------------
    // timed sequence windows, in cycles after the control write
    // -------------------------------------------------------------------
    localparam logic [2:0]  STORE_WINDOW = 3'h4;
    localparam logic [2:0]  LOAD_WINDOW  = 3'h3;
    // -------------------------------------------------------------------
    // readback pointer codes
    // -------------------------------------------------------------------
    localparam logic [15:0] PTR_FUSE_LOW = 16'h0000;
    localparam logic [15:0] PTR_LOCK     = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HI  = 16'h0003;
    localparam logic [4:0]  EXT_PAD      = 5'h1f;   // undefined upper bits
    localparam logic [7:0]  READ_BLOCKED = 8'hff;   // returned for blocked reads
    // -------------------------------------------------------------------
    // program time
    // -------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned PROG_MIN_NS    = 3_700_000;  // 3.7 ms
    localparam int unsigned PROG_MAX_NS    = 4_500_000;  // 4.5 ms
    localparam int unsigned PROG_CYCLES    = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [14:0] RWW_WORD_LIMIT = 15'h3800;   // first no-rww word
endpackage : fsp_pkg

// file: verilog/fsp_op_if.sv
/*
 * start/busy/done carrier between the sequencer and its operation timer.
 * assumes both ends sit on the same clock.
 */
interface fsp_op_if;
    logic start;   // one-cycle pulse: begin a timed operation
    logic busy;    // level: operation under way
    logic done;    // one-cycle pulse: operation finished
    modport ctrl  (output start, input  busy, input done);
    modport timer (input  start, output busy, output done);
endinterface : fsp_op_if

// file: verilog/fsp_op_timer.sv
/*
 * program-time counter for erase, write and lock programming.
 * assumes a power-on reset distinct from system reset, so that a
 * system reset cannot cut an operation short.
 */
module fsp_op_timer #(
    parameter int unsigned CYCLES = fsp_pkg::PROG_CYCLES
) (
    input  wire logic clk,
    input  wire logic power_on_rst,
    fsp_op_if.timer   op
);
    import fsp_pkg::*;

    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count;   // cycles spent in current operation
    logic          busy;    // operation under way

    // -------------------------------------------------------------------
    // counter: only power-on clears it, system reset is ignored
    // -------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (power_on_rst) begin
            busy  <= 1'b0;
            count <= '0;
        end else if (!busy && op.start) begin
            busy  <= 1'b1;   // RQ20
            count <= '0;
        end else if (busy) begin
            if (count == LAST) begin
                busy <= 1'b0;
            end
            count <= count + CW'(1);
        end
    end

    assign op.busy = busy;
    assign op.done = busy && (count == LAST);
endmodule // fsp_op_timer

// file: verilog/fsp_ctrl.sv
/*
 * flash self-programming sequencer: control byte, timed store/load
 * windows, rww blocking, lock programming and fuse/lock readback.
 * assumes the cpu core gives one-cycle instruction pulses on clk and that
 * the flash array answers an ordinary read combinationally.
 */
module fsp_ctrl #(
    parameter int unsigned PROG_TIME_CYCLES = fsp_pkg::PROG_CYCLES
) (
    input  wire  logic        clk,
    input  wire  logic        sys_rst,
    input  wire  logic        power_on_rst,
    input  wire  logic        ctrl_wr,
    input  wire  logic [7:0]  ctrl_wdata,
    output logic       [7:0]  ctrl_rdata,
    input  wire  logic        store_prog_instr,
    input  wire  logic        load_prog_instr,
    input  wire  logic [15:0] flash_addr_pointer,
    input  wire  logic [7:0]  work_reg_low,
    input  wire  logic [7:0]  work_reg_high,
    input  wire  logic        eeprom_write_busy,
    input  wire  logic        global_irq_enable,
    output logic              ready_irq,
    output logic [7:0]        load_data,
    output logic              load_valid,
    output logic [15:0]       flash_rd_addr,
    input  wire  logic [7:0]  flash_rd_data,
    output logic              rww_read_block,
    output logic              page_erase_start,
    output logic              page_write_start,
    output logic              page_buf_load,
    output logic              page_buf_clear,
    output logic [15:0]       page_buf_data,
    output logic [15:0]       page_addr,
    input  wire  logic [7:0]  lock_bits,
    output logic              lock_wr,
    output logic [7:0]        lock_wr_value,
    input  wire  logic [7:0]  fuse_low_byte,
    input  wire  logic [7:0]  fuse_high_byte,
    input  wire  logic [2:0]  fuse_extended_byte
);
    import fsp_pkg::*;

    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,   // no command armed
        ST_ARMED = 3'b010,   // command written, waiting for store/load
        ST_BUSY  = 3'b100    // timed operation running
    } fsp_state_type;

    fsp_state_type state;           // sequencer state
    fsp_state_type next_state;      // sequencer next state
    logic [4:0]    cmd;             // armed command bits 4..0
    logic          irq_en;          // ready_irq_enable
    logic          rww_busy;        // rww_busy_flag
    logic [2:0]    win;             // cycles left in store window
    logic          op_rww;          // running operation targets rww
    logic          store_take;      // store accepted this cycle
    logic          load_take;       // readback accepted this cycle
    logic          window_end;      // last window cycle, nothing taken
    logic          is_erase;        // decoded armed commands
    logic          is_write;
    logic          is_lock;
    logic          is_reen;
    logic          is_bufld;
    logic          ptr_in_rww;      // pointer addresses rww section
    logic [7:0]    readback;        // selected fuse/lock byte
    fsp_op_if      op ();           // timer carrier

    fsp_op_timer #(
        .CYCLES       (PROG_TIME_CYCLES)
    ) u_timer (
        .clk          (clk),
        .power_on_rst (power_on_rst),
        .op           (op.timer)
    );

    // -------------------------------------------------------------------
    // command decode
    // -------------------------------------------------------------------
    // decode of the armed pattern; only one action bit may ride with enable
    assign is_erase = cmd[BIT_ENABLE] && cmd[BIT_ERASE];                 // RQ21
    assign is_write = cmd[BIT_ENABLE] && cmd[BIT_WRITE];                 // RQ21
    assign is_lock  = cmd[BIT_ENABLE] && cmd[BIT_LOCK];                  // RQ5
    assign is_reen  = cmd[BIT_ENABLE] && cmd[BIT_RWW_EN];                // RQ4
    assign is_bufld = (cmd == 5'h01);                                    // RQ21
    assign ptr_in_rww = (flash_addr_pointer[15:1] < RWW_WORD_LIMIT);

    // store accepted inside the four-cycle window; eeprom write blocks it
    assign store_take = (state == ST_ARMED) && store_prog_instr && !eeprom_write_busy; // RQ10
    // readback only inside the first three window cycles
    assign load_take  = (state == ST_ARMED) && load_prog_instr && is_lock
                        && (win > (STORE_WINDOW - LOAD_WINDOW))           // RQ12
                        && !eeprom_write_busy;                            // RQ10
    assign window_end = (state == ST_ARMED) && (win == 3'h1) && !store_take && !load_take;

    // -------------------------------------------------------------------
    // state machine
    // -------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (ctrl_wr && ctrl_wdata[BIT_ENABLE] && !eeprom_write_busy) begin
                    next_state = ST_ARMED;                               // RQ10
                end
            end
            ST_ARMED: begin
                if (store_take && (is_erase || is_write || is_lock)) begin
                    next_state = ST_BUSY;                                // RQ25
                end else if (store_take || load_take || window_end) begin
                    next_state = ST_IDLE;                                // RQ13
                end
            end
            ST_BUSY: begin
                if (op.done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // a system reset while busy keeps the busy state, so the write finishes
    always_ff @(posedge clk) begin
        if (power_on_rst) begin
            state <= ST_IDLE;
        end else if (sys_rst && (state != ST_BUSY)) begin
            state <= ST_IDLE;                                            // RQ19
        end else begin
            state <= next_state;
        end
    end

    // -------------------------------------------------------------------
    // command bits and window counter
    // -------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (power_on_rst || (sys_rst && (state != ST_BUSY))) begin
            cmd <= CTRL_RESET[4:0];
            win <= 3'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // eeprom write in progress: command write is dropped
                    if (ctrl_wr && ctrl_wdata[BIT_ENABLE] && !eeprom_write_busy) begin
                        cmd <= ctrl_wdata[4:0];
                        win <= STORE_WINDOW;                             // RQ5
                    end
                end
                ST_ARMED: begin
                    win <= win - 3'h1;
                    // readback done, or timeout: lock_bit_set and enable drop
                    if (store_take || load_take || window_end) begin
                        if (!(store_take && (is_erase || is_write || is_lock))) begin
                            cmd <= 5'h00;                                // RQ13
                        end
                    end
                end
                ST_BUSY: begin
                    // enable bit stays up until the timer ends the operation
                    if (op.done) begin
                        cmd <= 5'h00;                                    // RQ25
                    end
                end
                default: begin
                    cmd <= 5'h00;
                end
            endcase
        end
    end

    // interrupt enable may be written at any time, even while busy, but not while an eeprom write is in progress
    always_ff @(posedge clk) begin
        if (sys_rst || power_on_rst) begin
            irq_en <= CTRL_RESET[BIT_IRQ_EN];
        end else if (ctrl_wr && !eeprom_write_busy) begin
            irq_en <= ctrl_wdata[BIT_IRQ_EN];
        end
    end

    // -------------------------------------------------------------------
    // rww busy flag
    // -------------------------------------------------------------------
    // re-enable only acts from armed, so it is never taken mid-operation
    always_ff @(posedge clk) begin
        if (power_on_rst) begin
            rww_busy <= CTRL_RESET[BIT_BUSY];
            op_rww   <= 1'b0;
        end else if (store_take && (is_erase || is_write)) begin
            rww_busy <= ptr_in_rww;                                      // RQ1
            op_rww   <= ptr_in_rww;
        end else if (store_take && is_lock) begin
            op_rww   <= 1'b0;                                            // RQ9
        end else if (store_take && (is_reen || is_bufld) && !op.busy) begin
            rww_busy <= 1'b0;                                            // RQ4 RQ22 RQ24
        end
    end

    // -------------------------------------------------------------------
    // flash array commands
    // -------------------------------------------------------------------
    // address and data are latched with the strobe; pointer free afterwards
    always_ff @(posedge clk) begin
        if (sys_rst || power_on_rst) begin
            page_erase_start <= 1'b0;
            page_write_start <= 1'b0;
            page_buf_load    <= 1'b0;
            page_buf_clear   <= 1'b0;
            page_buf_data    <= 16'h0000;
            page_addr        <= 16'h0000;
        end else begin
            page_erase_start <= store_take && is_erase;                  // RQ21
            page_write_start <= store_take && is_write;                  // RQ21
            page_buf_load    <= store_take && is_bufld;                  // RQ21
            page_buf_clear   <= store_take && is_reen && !op.busy;       // RQ4
            if (store_take) begin
                page_addr     <= flash_addr_pointer;
                page_buf_data <= {work_reg_high, work_reg_low};
            end
        end
    end

    assign op.start = store_take && (is_erase || is_write || is_lock);  // RQ20

    // -------------------------------------------------------------------
    // lock programming
    // -------------------------------------------------------------------
    // zero data bits 5..0 program their lock bit; ones keep it, as do bits 7,6; pointer unused
    always_ff @(posedge clk) begin
        if (sys_rst || power_on_rst) begin
            lock_wr       <= 1'b0;
            lock_wr_value <= 8'hff;
        end else begin
            lock_wr <= store_take && is_lock;                            // RQ5 RQ7
            if (store_take && is_lock) begin
                lock_wr_value <= {lock_bits[7:6], lock_bits[5:0] & work_reg_low[5:0]}; // RQ6
            end
        end
    end

    // -------------------------------------------------------------------
    // load path: readback or ordinary byte read
    // -------------------------------------------------------------------
    always_comb begin
        case (flash_addr_pointer)
            PTR_FUSE_LOW: readback = fuse_low_byte;                      // RQ15
            PTR_LOCK:     readback = lock_bits;                          // RQ12
            PTR_FUSE_EXT: readback = {EXT_PAD, fuse_extended_byte};      // RQ17
            PTR_FUSE_HI:  readback = fuse_high_byte;                     // RQ16
            default:      readback = READ_BLOCKED;
        endcase
    end

    assign flash_rd_addr = flash_addr_pointer;

    // stored bits are passed as is: programmed is zero, unprogrammed one
    always_ff @(posedge clk) begin
        if (sys_rst || power_on_rst) begin
            load_data  <= 8'h00;
            load_valid <= 1'b0;
        end else begin
            load_valid <= load_prog_instr;
            if (load_take) begin
                load_data <= readback;                                   // RQ18
            end else if (load_prog_instr) begin
                // blocked rww reads return all ones rather than stale array data
                load_data <= (rww_busy && ptr_in_rww) ? READ_BLOCKED : flash_rd_data; // RQ14 RQ1
            end
        end
    end

    // -------------------------------------------------------------------
    // status, block and interrupt outputs
    // -------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (power_on_rst) begin
            ctrl_rdata <= CTRL_RESET;
        end else begin
            ctrl_rdata <= {irq_en, rww_busy, 1'b0, cmd};
        end
    end

    assign rww_read_block = rww_busy;                                    // RQ1
    assign ready_irq      = irq_en && global_irq_enable && !cmd[BIT_ENABLE]; // RQ23

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || power_on_rst);

    int unsigned busy_len;   // cycles spent in busy, for the time check
    always_ff @(posedge clk) begin
        if (power_on_rst || state != ST_BUSY) begin
            busy_len <= 0;
        end else begin
            busy_len <= busy_len + 1;
        end
    end

    a_erase_sets_busy: assert property ( // RQ1
        store_take && is_erase && ptr_in_rww |=> rww_busy && rww_read_block)
        else $error("erase to rww did not set busy");
    a_reen_clears_busy: assert property ( // RQ4
        store_take && is_reen && !op.busy |=> !rww_busy ##0 page_buf_clear)
        else $error("re-enable did not clear busy");
    a_lock_value_and: assert property ( // RQ6
        store_take && is_lock |=> lock_wr && (lock_wr_value[5:0] == ($past(lock_bits[5:0]) & $past(work_reg_low[5:0]))))
        else $error("lock value wrong");
    a_lock_keeps_rww: assert property ( // RQ9
        store_take && is_lock && !rww_busy |=> !rww_busy)
        else $error("lock programming blocked rww");
    a_eeprom_blocks: assert property ( // RQ10
        eeprom_write_busy && state == ST_IDLE |=> state == ST_IDLE)
        else $error("command armed during eeprom write");
    a_window_timeout: assert property ( // RQ13
        state == ST_IDLE ##1 state == ST_ARMED && !store_prog_instr && !load_prog_instr [*4]
        |=> state == ST_IDLE && cmd == 5'h00)
        else $error("window did not expire after four cycles");
    a_fuse_low_read: assert property ( // RQ15
        load_take && flash_addr_pointer == PTR_FUSE_LOW |=> load_data == $past(fuse_low_byte) && load_valid)
        else $error("fuse low readback wrong");
    a_ext_fuse_read: assert property ( // RQ17
        load_take && flash_addr_pointer == PTR_FUSE_EXT |=> load_data[2:0] == $past(fuse_extended_byte))
        else $error("extended fuse readback wrong");
    a_enable_held: assert property ( // RQ25
        state == ST_BUSY && !op.done |=> cmd[BIT_ENABLE] && ctrl_rdata[BIT_ENABLE])
        else $error("enable dropped before operation end");
    a_prog_time: assert property ( // RQ20
        state == ST_BUSY && op.done |-> busy_len == PROG_TIME_CYCLES - 1)
        else $error("program time count wrong");
    a_ready_irq: assert property ( // RQ23
        irq_en && global_irq_enable && state == ST_IDLE |-> ready_irq)
        else $error("ready interrupt missing");
endmodule // fsp_ctrl

// file: bench/fsp_flash_model.sv
/*
 * far-side model: flash array read answer and lock-bit storage.
 * assumes the sequencer strobes lock_wr for one cycle on clk.
 */
module fsp_flash_model (
    input  wire logic        clk,
    input  wire logic        power_on_rst,
    input  wire logic [15:0] flash_rd_addr,
    output logic      [7:0]  flash_rd_data,
    input  wire logic        lock_wr,
    input  wire logic [7:0]  lock_wr_value,
    output logic      [7:0]  lock_bits
);
    timeunit 1ns;
    timeprecision 1ps;
    // array answers at once; the pattern differs for every low address byte and repeats every 256 bytes
    assign flash_rd_data = flash_rd_addr[7:0] ^ 8'h5a;
    // lock cells start unprogrammed, which reads as one
    always_ff @(posedge clk) begin
        if (power_on_rst) begin
            lock_bits <= 8'hff;
        end else if (lock_wr) begin
            lock_bits <= lock_wr_value;
        end
    end
endmodule // fsp_flash_model

// file: bench/tb.sv
/*
 * self-checking bench for fsp_ctrl: lock setting, readback, erase, eeprom block.
 * assumes a shortened program time of 20 cycles.
 */
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fsp_pkg::*;
    localparam int unsigned PT = 20;  // short program time keeps the run brief
    localparam logic [7:0]  FL = 8'ha3;
    localparam logic [7:0]  FH = 8'h1d;
    localparam logic [2:0]  FE = 3'h5;
    logic        clk = 0, sys_rst = 1, por = 1, ctrl_wr = 0, st = 0, ld = 0, ee = 0, gie = 0;
    logic [7:0]  ctrl_wdata = 0, wrl = 8'hff, rdata, ldata, fdata, lwv, lock, exp_lock = 8'hff, e;
    logic [15:0] ptr = 0, raddr;
    logic        irq, lvalid, rblk, erase, lwr, pws, pbl, pbc;
    logic [7:0]  wrh = 8'h00;
    logic [15:0] pbd, paddr;
    int          failures = 0, samples_checked = 0;
    always #20 clk = ~clk;
    fsp_ctrl #(.PROG_TIME_CYCLES(PT)) u_fsp_ctrl (.clk(clk), .sys_rst(sys_rst), .power_on_rst(por),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(rdata), .store_prog_instr(st),
        .load_prog_instr(ld), .flash_addr_pointer(ptr), .work_reg_low(wrl), .work_reg_high(wrh),
        .eeprom_write_busy(ee), .global_irq_enable(gie), .ready_irq(irq), .load_data(ldata),
        .load_valid(lvalid), .flash_rd_addr(raddr), .flash_rd_data(fdata), .rww_read_block(rblk),
        .page_erase_start(erase), .page_write_start(pws), .page_buf_load(pbl), .page_buf_clear(pbc),
        .page_buf_data(pbd), .page_addr(paddr), .lock_bits(lock), .lock_wr(lwr), .lock_wr_value(lwv),
        .fuse_low_byte(FL), .fuse_high_byte(FH), .fuse_extended_byte(FE));
    fsp_flash_model u_fsp_flash_model (.clk(clk), .power_on_rst(por), .flash_rd_addr(raddr),
        .flash_rd_data(fdata), .lock_wr(lwr), .lock_wr_value(lwv), .lock_bits(lock));
    // control write, then optional store or load in the first window cycle
    task automatic cmd(input logic [7:0] v, input logic s, input logic l);
        @(posedge clk);
        ctrl_wr <= 1'b1;
        ctrl_wdata <= v;
        @(posedge clk);
        ctrl_wr <= 1'b0;
        st <= s;
        ld <= l;
        @(posedge clk);
        st <= 1'b0;
        ld <= 1'b0;
        #1;
    endtask
    // ordinary load of one byte at the current pointer
    task automatic rd();
        @(posedge clk);
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        #1;
    endtask
    task automatic t_lock();
        wrl <= 8'hd6;
        ptr <= 16'h1234;
        cmd(8'h09, 1'b1, 1'b0);
        exp_lock = exp_lock & {2'b11, 6'h16};
        `CHK("lock strobe", 1'b1, lwr)
        `CHK("lock value", exp_lock[5:0], lwv[5:0])
        ptr <= 16'h0010;
        rd();
        `CHK("read in lock op", 8'h4a, ldata)
        `CHK("no block", 1'b0, rblk)
        `CHK("enable held", 1'b1, rdata[BIT_ENABLE])
        repeat (PT) @(posedge clk);
        #1;
        `CHK("enable done", 1'b0, rdata[BIT_ENABLE])
        $display("test lock done");
    endtask
    task automatic t_fuse();
        for (int i = 0; i < 4; i++) begin
            ptr <= 16'(i);
            cmd(8'h09, 1'b0, 1'b1);
            e = (i == 0) ? FL : (i == 1) ? exp_lock : (i == 2) ? {EXT_PAD, FE} : FH;
            `CHK("readback valid", 1'b1, lvalid)
            `CHK("readback data", e, ldata)
            @(posedge clk);
            #1;
            `CHK("auto clear", 1'b0, rdata[BIT_ENABLE])
        end
        $display("test fuse done");
    endtask
    task automatic t_erase();
        ptr <= 16'h0100;
        cmd(8'h03, 1'b1, 1'b0);
        `CHK("erase strobe", 1'b1, erase)
        `CHK("rww block", 1'b1, rblk)
        `CHK("erase page", 16'h0100, paddr)
        rd();
        `CHK("blocked read", READ_BLOCKED, ldata)
        cmd(8'h11, 1'b1, 1'b0);
        `CHK("early enable", 1'b1, rblk)
        // system reset in mid-operation must not cut the erase short
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("reset keeps op", 1'b1, rdata[BIT_ENABLE])
        repeat (PT) @(posedge clk);
        #1;
        `CHK("still busy", 1'b1, rblk)
        cmd(8'h11, 1'b1, 1'b0);
        `CHK("rww open", 1'b0, rblk)
        `CHK("buffer clear", 1'b1, pbc)
        rd();
        `CHK("read after", 8'h5a, ldata)
        cmd(8'h05, 1'b1, 1'b0);
        `CHK("write strobe", 1'b1, pws)
        `CHK("write blocks", 1'b1, rblk)
        repeat (PT) @(posedge clk);
        wrh <= 8'hc3;
        cmd(8'h01, 1'b1, 1'b0);
        `CHK("load strobe", 1'b1, pbl)
        `CHK("buffer data", 16'hc3d6, pbd)
        `CHK("load frees rww", 1'b0, rblk)
        $display("test erase done");
    endtask
    task automatic t_eeprom();
        ee <= 1'b1;
        ptr <= 16'h0000;
        cmd(8'h03, 1'b1, 1'b0);
        `CHK("erase blocked", 1'b0, erase)
        cmd(8'h09, 1'b0, 1'b1);
        `CHK("fuse blocked", 8'h5a, ldata)
        ee <= 1'b0;
        $display("test eeprom done");
    endtask
    task automatic t_timeout();
        gie <= 1'b1;
        ptr <= 16'h0003;
        cmd(8'h89, 1'b0, 1'b0);
        repeat (6) @(posedge clk);
        #1;
        `CHK("window lapse", 1'b0, rdata[BIT_ENABLE])
        `CHK("ready irq", 1'b1, irq)
        rd();
        `CHK("plain load", 8'h59, ldata)
        $display("test timeout done");
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        por <= 1'b0;
        t_lock();
        t_fuse();
        t_erase();
        t_eeprom();
        t_timeout();
        final_report();
    end
    // watchdog: the whole sequence needs well under 400 cycles
    initial begin
        #(40 * 2000);
        failures++;
        final_report();
    end
endmodule // tb
